// ===== verilog/spp_pkg.sv
// shared constants and types for the six pin port with eeprom lines
package spp_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_DATA = 8'h05;
  localparam logic [7:0] ADDR_TIMER_PULLUP_CONFIG = 8'h81;
  localparam logic [7:0] ADDR_PORT_DIRECTION = 8'h85;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL_MIRROR = 8'h8b;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 6;
  localparam int BIT_PIN_THREE = 3;
  localparam int BIT_PIN_FOUR = 4;
  localparam int BIT_EEPROM_DATA = 6;
  localparam int BIT_EEPROM_CLOCK = 7;
  localparam int BIT_PULLUP_DISABLE = 7;
  localparam int BIT_CHANGE_ENABLE = 3;
  localparam int BIT_PORT_CHANGE_FLAG = 0;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT_LATCH = 8'hc0;
  localparam logic [5:0] RST_PORT_DIRECTION = 6'h3f;
  localparam logic [7:0] RST_TIMER_PULLUP_CONFIG = 8'hff;
  localparam logic [5:0] RST_PIN_SYNC = 6'h00;
  localparam logic [2:0] RST_PIN_SNAPSHOT = 3'h0;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_LP_CRYSTAL = 3'b000,
    OSC_XT_CRYSTAL = 3'b001,
    OSC_HS_CRYSTAL = 3'b010,
    OSC_INTERNAL_RC = 3'b011,
    OSC_EXTERNAL_RC = 3'b100
  } spp_osc_type;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_BIT_SET = 2'b01,
    OP_BIT_CLEAR = 2'b10,
    OP_NONE = 2'b11
  } spp_op_type;

endpackage

// ===== verilog/spp_eeprom_if.sv
// line levels and bus conditions of the internal eeprom link
`timescale 1ns/1ps
interface spp_eeprom_if;
  logic dataLine;
  logic clockLine;
  logic startSeen;
  logic stopSeen;

  // the port side drives the line levels and reads the conditions
  modport port (output dataLine, output clockLine, input startSeen, input stopSeen);
  // the watcher reads line levels and reports conditions
  modport watch (input dataLine, input clockLine, output startSeen, output stopSeen);
endinterface

// ===== verilog/spp_sync3.sv
// three flop input synchroniser, change taken once stages two and three agree
`timescale 1ns/1ps
module spp_sync3 import spp_pkg::*; #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstB,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] agree;

  // only stages two and three are compared, stage one feeds stage two alone
  assign agree = ~(stage2_q ^ stage3_q);
  assign syncOut = out_q;

  // shift chain
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      out_q <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      out_q <= (agree & stage3_q) | (~agree & out_q);
    end
  end

endmodule // spp_sync3

// ===== verilog/spp_bus_cond.sv
// start and stop condition watcher on the internal eeprom lines
`timescale 1ns/1ps
module spp_bus_cond (
  // clock and reset
  input wire logic clk,
  input wire logic rstB,
  // link
  spp_eeprom_if.watch link
);

  logic dataPrev_q;
  logic clockPrev_q;
  logic start_q;
  logic stop_q;
  logic clockHeld;
  logic startHit;
  logic stopHit;

  // a data edge while the clock stays high is a condition, never a data bit
  assign clockHeld = clockPrev_q & link.clockLine;
  assign startHit = clockHeld & dataPrev_q & ~link.dataLine;
  assign stopHit = clockHeld & ~dataPrev_q & link.dataLine;
  assign link.startSeen = start_q;
  assign link.stopSeen = stop_q;

  // idle bus is both lines high
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      dataPrev_q <= 1'b1;
      clockPrev_q <= 1'b1;
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      dataPrev_q <= link.dataLine;
      clockPrev_q <= link.clockLine;
      start_q <= startHit;
      stop_q <= stopHit;
    end
  end

endmodule // spp_bus_cond

// ===== verilog/spp_port.sv
// six pin general purpose port with two internal eeprom line bits
`timescale 1ns/1ps
module spp_port import spp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port of the core
  input wire logic [7:0] regAddr,
  input wire logic regRdEn,
  input wire logic regWrEn,
  input wire logic [1:0] regOp,
  input wire logic [2:0] regBitSel,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // configuration word and analog selection
  input wire logic [2:0] oscMode,
  input wire logic masterClearEn,
  input wire logic clockOutEn,
  input wire logic clockOutSrc,
  input wire logic [5:0] analogSel,
  // external pins
  input wire logic [5:0] pinIn,
  output logic [5:0] pinOut,
  output logic [5:0] pinOe,
  output logic [5:0] pullupEn,
  // internal eeprom lines
  input wire logic eepromDataIn,
  output logic eepromDataOut,
  output logic eepromDataOe,
  output logic eepromClockOut,
  output logic eepromStart,
  output logic eepromStop,
  // status
  output logic portChangeFlag
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta_q;
  logic rstSyncB_q;

  // async assert, clocked release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSyncB_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncB_q <= rstMeta_q;
    end
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [5:0] dir_q;
  logic [5:0] dir_d;
  logic [7:0] option_q;
  logic [7:0] option_d;
  logic changeEn_q;
  logic changeFlag_q;
  logic [2:0] snap_q;
  logic [7:0] rdData_q;
  logic dataOe_q;
  logic [5:0] pinOut_q;
  logic [5:0] pinOe_q;
  logic [5:0] pullup_q;
  logic [5:0] pinSync;
  logic rcMode;
  logic clockOutActive;
  logic [5:0] altFunc;
  logic [5:0] dirEff;
  logic [7:0] dirRead;
  logic [7:0] portRead;
  logic [7:0] ctrlRead;
  logic [7:0] rdMux;
  logic hitPort;
  logic hitDir;
  logic hitOption;
  logic hitCtrl;
  logic accessOp;
  logic [7:0] portNew;
  logic [7:0] dirNew;
  logic [7:0] optionNew;
  logic [7:0] ctrlNew;
  logic portSample;
  logic [2:0] changeMask;
  logic [2:0] changeNow;
  logic changeHit;
  logic dataLine;

  spp_eeprom_if eeLink ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // write types: plain write, or modify one bit of the read value
  function automatic logic [7:0] applyOp(input logic [7:0] base, input logic [1:0] op,
                                         input logic [7:0] data, input logic [2:0] sel);
    logic [7:0] res;
    res = base;
    case (op)
      OP_WRITE: res = data;
      OP_BIT_SET: res[sel] = 1'b1;
      OP_BIT_CLEAR: res[sel] = 1'b0;
      default: res = base;
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------
  // pin input synchroniser and eeprom watcher
  // ---------------------------------------------------------------
  spp_sync3 #(
    .WIDTH(PIN_COUNT)
  ) pinSyncInst (
    .clk(core_clk),
    .rstB(rstSyncB_q),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  spp_bus_cond busCondInst (
    .clk(core_clk),
    .rstB(rstSyncB_q),
    .link(eeLink.watch)
  );

  // open drain data line, the eeprom may pull it low too
  assign dataLine = latch_q[BIT_EEPROM_DATA] & eepromDataIn;
  assign eeLink.dataLine = dataLine;
  assign eeLink.clockLine = latch_q[BIT_EEPROM_CLOCK];

  // ---------------------------------------------------------------
  // configuration overrides
  // ---------------------------------------------------------------
  // only the rc oscillators leave pins four and five to the port
  assign rcMode = (oscMode == OSC_INTERNAL_RC) || (oscMode == OSC_EXTERNAL_RC);
  assign clockOutActive = rcMode & clockOutEn;
  // pins taken by analog, master clear or oscillator
  assign altFunc = {~rcMode, ~rcMode | clockOutActive, masterClearEn, 3'b000}
                 | (analogSel & 6'h17);

  // effective direction, pin three never drives
  assign dirEff = {rcMode ? dir_q[5:4] : 2'b11, 1'b0, dir_q[2:0]} | 6'h08;
  assign dirRead = {2'b00, dirEff};

  // ---------------------------------------------------------------
  // read values
  // ---------------------------------------------------------------
  // pin levels at the moment of the read, alternates read zero
  assign portRead = {eeLink.clockLine, dataLine, pinSync & ~altFunc};
  assign ctrlRead = {4'h0, changeEn_q, 2'b00, changeFlag_q};

  // address decode, both banks of the interrupt control reach one register
  assign hitPort = regAddr == ADDR_PORT_DATA;
  assign hitDir = regAddr == ADDR_PORT_DIRECTION;
  assign hitOption = regAddr == ADDR_TIMER_PULLUP_CONFIG;
  assign hitCtrl = (regAddr == ADDR_INTERRUPT_CONTROL)
                 || (regAddr == ADDR_INTERRUPT_CONTROL_MIRROR);
  assign accessOp = regWrEn && (regOp != OP_NONE);

  // unmapped addresses read zero
  assign rdMux = hitPort ? portRead :
                 hitDir ? dirRead :
                 hitOption ? option_q :
                 hitCtrl ? ctrlRead : 8'h00;

  // ---------------------------------------------------------------
  // write values
  // ---------------------------------------------------------------
  // modify starts from pins, so input latches take pin levels
  assign portNew = applyOp(portRead, regOp, regWrData, regBitSel);
  assign dirNew = applyOp(dirRead, regOp, regWrData, regBitSel);
  assign optionNew = applyOp(option_q, regOp, regWrData, regBitSel);
  assign ctrlNew = applyOp(ctrlRead, regOp, regWrData, regBitSel);

  // output latches hold all eight bits until written
  assign latch_d = (accessOp && hitPort) ? portNew : latch_q;
  // bit four frozen while clock output is on
  assign dir_d = (accessOp && hitDir)
               ? {dirNew[5], clockOutActive ? dir_q[4] : dirNew[4], dirNew[3:0]}
               : dir_q;
  assign option_d = (accessOp && hitOption) ? optionNew : option_q;

  // ---------------------------------------------------------------
  // change detection
  // ---------------------------------------------------------------
  // a port read or port write op samples the snapshot
  assign portSample = hitPort && (regRdEn || accessOp);
  // one shared setting, master clear leaves pin three out
  assign changeMask = {~masterClearEn, 2'b11};
  assign changeNow = {pinSync[BIT_PIN_THREE], pinSync[1:0]};
  // nothing is detected until the enable is set
  assign changeHit = changeEn_q && |((changeNow ^ snap_q) & changeMask);

  // snapshot of the change pins
  always_ff @(posedge core_clk or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      snap_q <= RST_PIN_SNAPSHOT;
    end else if (portSample) begin
      snap_q <= changeNow;
    end
  end

  // interrupt control enable and flag, set beats clear
  always_ff @(posedge core_clk or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      changeEn_q <= 1'b0;
      changeFlag_q <= 1'b0;
    end else begin
      if (accessOp && hitCtrl) begin
        changeEn_q <= ctrlNew[BIT_CHANGE_ENABLE];
      end
      if (changeHit) begin
        changeFlag_q <= 1'b1;
      end else if (accessOp && hitCtrl) begin
        changeFlag_q <= ctrlNew[BIT_PORT_CHANGE_FLAG];
      end
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  // all direction bits one on reset
  always_ff @(posedge core_clk or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      latch_q <= RST_PORT_LATCH;
      dataOe_q <= ~RST_PORT_LATCH[BIT_EEPROM_DATA];
      dir_q <= RST_PORT_DIRECTION;
      option_q <= RST_TIMER_PULLUP_CONFIG;
    end else begin
      latch_q <= latch_d;
      dataOe_q <= ~latch_d[BIT_EEPROM_DATA]; // pull enable tracks latch, no extra lag
      dir_q <= dir_d;
      option_q <= option_d;
    end
  end

  // read data answers one edge after the strobe, holds until next read
  always_ff @(posedge core_clk or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      rdData_q <= 8'h00;
    end else if (regRdEn) begin
      rdData_q <= rdMux;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // one floats the driver, zero drives the latch; one cycle behind the
  // registers so every output leaves a flop
  always_ff @(posedge core_clk or negedge rstSyncB_q) begin
    if (!rstSyncB_q) begin
      pinOut_q <= 6'h00;
      pinOe_q <= 6'h00;
      pullup_q <= 6'h00;
    end else begin
      pinOut_q <= latch_q[5:0];
      pinOe_q <= ~dirEff & ~altFunc;
      // clock output drives pin four whatever its direction bit
      if (clockOutActive) begin
        pinOut_q[BIT_PIN_FOUR] <= clockOutSrc;
        pinOe_q[BIT_PIN_FOUR] <= 1'b1;
      end
      // one pull-up setting, pin three's forced on under master clear
      pullup_q <= {2'b00, ~option_q[BIT_PULLUP_DISABLE] | masterClearEn, 1'b0,
                   {2{~option_q[BIT_PULLUP_DISABLE]}}};
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // line timing is firmware's duty, the port just mirrors latches
  assign regRdData = rdData_q;
  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign pullupEn = pullup_q;
  assign eepromDataOut = 1'b0;
  assign eepromDataOe = dataOe_q;
  assign eepromClockOut = latch_q[BIT_EEPROM_CLOCK];
  assign eepromStart = eeLink.startSeen;
  assign eepromStop = eeLink.stopSeen;
  assign portChangeFlag = changeFlag_q;

endmodule // spp_port

// ===== verif/spp_port_chk.sv
// concurrent checks on the six pin port boundary
`timescale 1ns/1ps
module spp_port_chk import spp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // configuration
  input wire logic [2:0] oscMode,
  input wire logic masterClearEn,
  input wire logic [5:0] analogSel,
  // pins and eeprom lines
  input wire logic [5:0] pinOe,
  input wire logic [5:0] pullupEn,
  input wire logic eepromDataIn,
  input wire logic eepromDataOe,
  input wire logic eepromClockOut,
  input wire logic eepromStart,
  input wire logic eepromStop
);
  logic [2:0] upCnt_q;
  logic [2:0] upCnt_d;
  logic settled;
  logic dataLine;
  // cycles since release; the internal reset lags by two flops
  assign upCnt_d = (upCnt_q == 3'h7) ? upCnt_q : upCnt_q + 3'h1;
  assign settled = (upCnt_q == 3'h7);
  // open drain data line as the eeprom sees it
  assign dataLine = ~eepromDataOe & eepromDataIn;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) upCnt_q <= 3'h0;
    else upCnt_q <= upCnt_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // data line edges while the clock line stays high
  sequence s_data_fall;
    settled && eepromClockOut && dataLine ##1 eepromClockOut && !dataLine;
  endsequence
  sequence s_data_rise;
    settled && eepromClockOut && !dataLine ##1 eepromClockOut && dataLine;
  endsequence
  a_pin3_no_drive: assert property (pinOe[3] == 1'b0)
    else $error("pin three driven");
  a_pullup_shared: assert property (
    pullupEn[0] == pullupEn[1] && pullupEn[5:4] == 2'b00 && !pullupEn[2])
    else $error("pull-up not shared");
  a_master_clear_input_pullup_on: assert property ((settled && masterClearEn)[*2] |-> pullupEn[3])
    else $error("clear input pull-up off");
  a_crystal_pins_off: assert property (
    (settled && oscMode < 3'h3)[*2] |-> pinOe[5:4] == 2'b00)
    else $error("oscillator pins driven");
  a_dir_reads_one: assert property (
    regRdEn && regAddr == ADDR_PORT_DIRECTION |=> regRdData[3] && regRdData[7:6] == 2'b00)
    else $error("direction readback wrong");
  a_alt_reads_zero: assert property (
    regRdEn && regAddr == ADDR_PORT_DATA && analogSel[0] |=> !regRdData[0])
    else $error("analog pin read nonzero");
  a_master_clear_input_reads_zero: assert property (
    regRdEn && regAddr == ADDR_PORT_DATA && masterClearEn |=> !regRdData[3])
    else $error("clear input read nonzero");
  a_rdata_holds: assert property (settled && !regRdEn |=> $stable(regRdData))
    else $error("read data moved");
  a_start_detect: assert property (s_data_fall |=> eepromStart)
    else $error("start missed");
  a_stop_detect: assert property (s_data_rise |=> eepromStop)
    else $error("stop missed");
endmodule // spp_port_chk

bind spp_port spp_port_chk spp_port_chk_inst (.core_clk(core_clk), .rst_b(rst_b),
  .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .oscMode(oscMode),
  .masterClearEn(masterClearEn), .analogSel(analogSel), .pinOe(pinOe), .pullupEn(pullupEn),
  .eepromDataIn(eepromDataIn), .eepromDataOe(eepromDataOe), .eepromClockOut(eepromClockOut),
  .eepromStart(eepromStart), .eepromStop(eepromStop));

// ===== verif/spp_pin_model.sv
// external pins and internal eeprom pull for the port
`timescale 1ns/1ps
module spp_pin_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOe,
  input wire logic [5:0] pullupEn,
  // bench controls
  input wire logic [5:0] extDrive,
  input wire logic [5:0] extEn,
  input wire logic ackPull,
  // levels seen by the device
  output logic [5:0] pinIn,
  output logic eepromDataIn
);
  logic [5:0] floatPat_q = 6'h15;
  // undriven pins wander so a floating read never looks settled
  always_ff @(posedge clk)
    floatPat_q <= ~floatPat_q;
  // strong outside drive wins, then driver, then pull-up
  always_comb
    for (int i = 0; i < 6; i++)
      pinIn[i] = extEn[i] ? extDrive[i] : pinOe[i] ? pinOut[i] : pullupEn[i] | floatPat_q[i];
  // eeprom pulls its data line low only when told
  assign eepromDataIn = ~ackPull;
endmodule // spp_pin_model

// ===== verif/spp_port_tb_top.sv
// self-checking bench for the six pin port
`timescale 1ns/1ps
module spp_port_tb_top import spp_pkg::*;;
  logic core_clk, rst_b, regRdEn, regWrEn, masterClearEn, clockOutEn, clockOutSrc, ackPull;
  logic [7:0] regAddr, regWrData, regRdData, v;
  logic [1:0] regOp;
  logic [2:0] regBitSel, oscMode;
  logic [5:0] analogSel, pinIn, pinOut, pinOe, pullupEn, extDrive, extEn;
  logic eepromDataIn, eepromDataOe, eepromClockOut, eepromStart, eepromStop, portChangeFlag;
  logic eepromDataOut;
  int n_mismatch, compares, nStart, nStop, s0, p0;

  spp_port spp_port_inst (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regRdEn(regRdEn), .regWrEn(regWrEn), .regOp(regOp), .regBitSel(regBitSel),
    .regWrData(regWrData), .regRdData(regRdData), .oscMode(oscMode),
    .masterClearEn(masterClearEn), .clockOutEn(clockOutEn), .clockOutSrc(clockOutSrc),
    .analogSel(analogSel), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pullupEn(pullupEn), .eepromDataIn(eepromDataIn), .eepromDataOut(eepromDataOut),
    .eepromDataOe(eepromDataOe), .eepromClockOut(eepromClockOut),
    .eepromStart(eepromStart), .eepromStop(eepromStop), .portChangeFlag(portChangeFlag));
  spp_pin_model spp_pin_model_inst (.clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullupEn(pullupEn), .extDrive(extDrive), .extEn(extEn), .ackPull(ackPull),
    .pinIn(pinIn), .eepromDataIn(eepromDataIn));

  // clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // count condition pulses on the eeprom lines
  always @(posedge core_clk) begin
    if (eepromStart === 1'b1) nStart++;
    if (eepromStop === 1'b1) nStop++;
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // write-type op; extra cycles let the pin registers follow
  task automatic wr(input logic [7:0] a, input logic [1:0] op, input logic [2:0] b,
    input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a; regOp <= op; regBitSel <= b; regWrData <= d; regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0; regOp <= OP_NONE;
    idle(2);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask
  // outside levels; five cycles cover the three flop synchroniser
  task automatic ext(input logic [5:0] en, input logic [5:0] dv);
    @(posedge core_clk);
    extEn <= en; extDrive <= dv;
    idle(5);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(ADDR_PORT_DIRECTION, v); chk(v, 8'h3f, "dir after reset");
    rd(ADDR_PORT_DATA, v); chk(v, 8'he8, "analog pins read");
    chk({2'h0, pinOe}, 8'h00, "drivers after reset");
    @(posedge core_clk) analogSel <= 6'h00;
  endtask
  task automatic t_dir;
    wr(ADDR_PORT_DIRECTION, OP_WRITE, 3'h0, 8'h00);
    rd(ADDR_PORT_DIRECTION, v); chk(v, 8'h08, "input only bit");
    chk({2'h0, pinOe}, 8'h37, "all outputs");
    wr(ADDR_PORT_DATA, OP_WRITE, 3'h0, 8'hc1);
    ext(6'h01, 6'h00);
    chk({2'h0, pinOut & pinOe}, 8'h01, "latch drive");
    rd(ADDR_PORT_DATA, v); chk(v & 8'h01, 8'h00, "pin not latch");
  endtask
  task automatic t_rmw;
    wr(ADDR_PORT_DIRECTION, OP_WRITE, 3'h0, 8'h3f);
    ext(6'h3f, 6'h0a);
    wr(ADDR_PORT_DATA, OP_BIT_SET, 3'h5, 8'h00);
    ext(6'h00, 6'h00);
    wr(ADDR_PORT_DIRECTION, OP_WRITE, 3'h0, 8'h00);
    chk({2'h0, pinOut & pinOe}, 8'h22, "set took pins");
    idle(5);
    wr(ADDR_PORT_DATA, OP_BIT_CLEAR, 3'h5, 8'h00);
    chk({2'h0, pinOut & pinOe}, 8'h02, "clear kept latch");
  endtask
  task automatic t_osc;
    @(posedge core_clk) oscMode <= OSC_XT_CRYSTAL;
    idle(3);
    rd(ADDR_PORT_DIRECTION, v); chk(v, 8'h38, "crystal dir");
    chk({2'h0, pinOe}, 8'h07, "crystal pins off");
    @(posedge core_clk) oscMode <= OSC_LP_CRYSTAL;
    idle(3);
    rd(ADDR_PORT_DIRECTION, v); chk(v, 8'h38, "low power crystal dir");
    @(posedge core_clk) oscMode <= OSC_HS_CRYSTAL;
    idle(3);
    chk({2'h0, pinOe}, 8'h07, "fast crystal pins off");
    @(posedge core_clk) begin
      oscMode <= OSC_EXTERNAL_RC; clockOutEn <= 1'b1; clockOutSrc <= 1'b1;
    end
    wr(ADDR_PORT_DIRECTION, OP_WRITE, 3'h0, 8'h10);
    chk({2'h0, pinOe}, 8'h37, "clock out drives");
    chk({2'h0, pinOut & 6'h10}, 8'h10, "clock out level");
    rd(ADDR_PORT_DIRECTION, v); chk(v, 8'h08, "bit four kept");
    @(posedge core_clk) clockOutEn <= 1'b0;
  endtask
  task automatic t_master_clear_input;
    @(posedge core_clk) masterClearEn <= 1'b1;
    ext(6'h3f, 6'h08);
    chk({2'h0, pullupEn}, 8'h08, "clear input pull-up");
    rd(ADDR_PORT_DATA, v); chk(v & 8'h08, 8'h00, "clear input read");
    wr(ADDR_TIMER_PULLUP_CONFIG, OP_WRITE, 3'h0, 8'h7f);
    chk({2'h0, pullupEn}, 8'h0b, "shared pull-ups");
    @(posedge core_clk) masterClearEn <= 1'b0;
    wr(ADDR_TIMER_PULLUP_CONFIG, OP_WRITE, 3'h0, 8'hff);
    chk({2'h0, pullupEn}, 8'h00, "pull-ups off");
  endtask
  task automatic t_change;
    wr(ADDR_PORT_DIRECTION, OP_WRITE, 3'h0, 8'h3f);
    ext(6'h3f, 6'h00);
    rd(ADDR_PORT_DATA, v);
    ext(6'h3f, 6'h01);
    chk({7'h0, portChangeFlag}, 8'h00, "disabled change");
    rd(ADDR_PORT_DATA, v);
    wr(ADDR_INTERRUPT_CONTROL, OP_WRITE, 3'h0, 8'h08);
    ext(6'h3f, 6'h05);
    chk({7'h0, portChangeFlag}, 8'h00, "pin two ignored");
    ext(6'h3f, 6'h07);
    rd(ADDR_INTERRUPT_CONTROL, v); chk(v, 8'h09, "flag set");
    idle(4); chk({7'h0, portChangeFlag}, 8'h01, "flag sticky");
    rd(ADDR_PORT_DATA, v);
    wr(ADDR_INTERRUPT_CONTROL, OP_WRITE, 3'h0, 8'h08);
    idle(3); chk({7'h0, portChangeFlag}, 8'h00, "flag cleared");
    wr(ADDR_INTERRUPT_CONTROL, OP_WRITE, 3'h0, 8'h00);
  endtask
  task automatic t_eeprom;
    s0 = nStart; p0 = nStop;
    wr(ADDR_PORT_DATA, OP_BIT_CLEAR, 3'h6, 8'h00);
    chk({5'h0, eepromClockOut, eepromDataOe, eepromDataOut}, 8'h06, "eeprom line drive");
    wr(ADDR_PORT_DATA, OP_BIT_CLEAR, 3'h7, 8'h00);
    wr(ADDR_PORT_DATA, OP_BIT_SET, 3'h6, 8'h00);
    @(posedge core_clk) ackPull <= 1'b1;
    rd(ADDR_PORT_DATA, v); chk(v & 8'hc0, 8'h00, "eeprom pulls data");
    @(posedge core_clk) ackPull <= 1'b0;
    wr(ADDR_PORT_DATA, OP_BIT_CLEAR, 3'h6, 8'h00);
    wr(ADDR_PORT_DATA, OP_BIT_SET, 3'h7, 8'h00);
    wr(ADDR_PORT_DATA, OP_BIT_SET, 3'h6, 8'h00);
    chk(8'(nStart - s0), 8'h01, "start count");
    chk(8'(nStop - p0), 8'h01, "stop count");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_b = 1'b0; regAddr = 8'h00; regRdEn = 1'b0; regWrEn = 1'b0; regOp = OP_NONE;
    regBitSel = 3'h0; regWrData = 8'h00; oscMode = OSC_INTERNAL_RC; masterClearEn = 1'b0;
    clockOutEn = 1'b0; clockOutSrc = 1'b0; analogSel = 6'h17; extEn = 6'h3f;
    extDrive = 6'h3f; ackPull = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    idle(3);
    t_reset; t_dir; t_rmw; t_osc; t_master_clear_input; t_change; t_eeprom;
    tally_and_finish;
  end
  // a few hundred cycles are expected; far beyond that is a hang
  initial begin
    #160000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // spp_port_tb_top
